// [logic/pmt_tone_gain.sv]
// pulse metering tone generator with cadence timers and audio gain control
// Notes on behaviour
// RL1: oscillator frequency follows coefficient bits 15:3, cosine at 64 kHz sampling, Q14.
// RL2: amplitude coefficient scales oscillator output against half-volt full scale.
// RL3: every sinusoid sample is multiplied by envelope volume before the DAC.
// RL4: while tone on, volume rises by step value at every 8 kHz tick.
// RL5: volume starts at zero and saturates at 7FFF during attack.
// RL6: attack halts while transmit level exceeds the AGC threshold.
// RL7: tone off makes volume fall by step each tick down to zero.
// RL8: on and off cadence timers are 16 bits, 125 us per count.
// RL9: each timer expiry sets its own flag when its enable bit is set.
// RL10: control holds generator, on-timer, off-timer enables and read-only waveform present.
// RL11: writing 0 to impedance bit switches off series, pole and zero coefficients.
// RL12: transmit attenuation 0 gives nominal gain, 1 adds 3 dB.
// RL13: transmit mute silences transmit output regardless of attenuation.
// RL14: receive attenuation 00, 01, 10 give 0, 3.5, 6 dB attenuation.
// RL15: receive mute suppresses line output regardless of attenuation field.
// RL16: host never writes receive attenuation code 11; it is reserved.
// RL17: with both timers on, on-expiry starts decay, off-expiry restarts tone.
`timescale 1ns/1ns
module pmt_tone_gain import pmt_pkg::*; #(
    parameter int TICK_CYC = PMT_TICK_CYC,      // cycles per 8 kHz tick
    parameter int SAMPLE_CYC = PMT_SAMPLE_CYC   // cycles per 64 kHz sample
) (
    input wire logic CLK_I,                 // 125 MHz clock
    input wire logic NRST_I,                // sync reset, active low
    input wire logic [6:0] REG_ADDR_I,      // register index
    input wire logic [15:0] REG_WDATA_I,    // write data
    input wire logic REG_WE_I,              // write strobe, one cycle
    input wire logic REG_RE_I,              // read strobe, one cycle
    output logic [15:0] REG_RDATA_O,        // read data, registered
    input wire logic [15:0] TX_LEVEL_I,     // transmit path magnitude
    output logic signed [15:0] TONE_DAC_O,  // enveloped tone sample
    output logic TX_ATTEN_O,                // transmit extra 3 dB
    output logic TX_MUTE_O,                 // transmit muted
    output logic [1:0] RX_ATTEN_O,          // receive attenuation code
    output logic RX_MUTE_O,                 // receive muted
    output logic IMPEDANCE_ON_O             // analog impedance coefs on
);
    localparam int TW = $clog2(TICK_CYC);
    localparam int SW = $clog2(SAMPLE_CYC);

    logic [15:0] tone_frequency_coefficient;
    logic [15:0] tone_amplitude_coefficient;
    logic [15:0] tone_envelope_step;
    logic [15:0] tone_on_period;
    logic [15:0] tone_off_period;
    logic [15:0] tone_agc_threshold;
    logic tone_generator_enable;
    logic tone_on_timer_enable;
    logic tone_off_timer_enable;
    logic tone_waveform_present;
    logic [4:0] audio_gain_control;
    logic [1:0] interrupt_flags_first;
    logic [1:0] interrupt_enables_first;
    logic impedance_synthesis_off;
    logic [TW-1:0] tick_cnt;
    logic [SW-1:0] samp_cnt;
    logic tick;
    logic samp;
    logic [15:0] volume;
    logic [16:0] vol_up;
    logic [15:0] timer;
    pmt_state_t state;
    logic tone_on;
    logic on_expire;
    logic off_expire;
    logic clear_flags;
    logic signed [15:0] osc_sample;
    logic signed [31:0] shaped;

    function automatic logic hit(input logic [6:0] a);
        hit = REG_WE_I && (REG_ADDR_I == a);
    endfunction

    // 8 kHz and 64 kHz enables from the one clock
    always_ff @(posedge CLK_I) begin
        if (!NRST_I || tick) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= tick_cnt + TW'(1);
        end
    end
    assign tick = (tick_cnt == TW'(TICK_CYC - 1)); // RL8

    always_ff @(posedge CLK_I) begin
        if (!NRST_I || samp) begin
            samp_cnt <= '0;
        end else begin
            samp_cnt <= samp_cnt + SW'(1);
        end
    end
    assign samp = (samp_cnt == SW'(SAMPLE_CYC - 1));

    // coefficient, threshold and timer period registers
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            tone_frequency_coefficient <= PMT_RST_ZERO;
            tone_amplitude_coefficient <= PMT_RST_ZERO;
            tone_envelope_step <= PMT_RST_ZERO;
            tone_agc_threshold <= PMT_RST_ZERO;
            tone_on_period <= PMT_RST_ZERO;
            tone_off_period <= PMT_RST_ZERO;
        end else begin
            if (hit(PMT_REG_FREQ)) tone_frequency_coefficient <= REG_WDATA_I;
            if (hit(PMT_REG_AMPL)) tone_amplitude_coefficient <= REG_WDATA_I;
            if (hit(PMT_REG_STEP)) tone_envelope_step <= REG_WDATA_I;
            if (hit(PMT_REG_AGC_TH)) tone_agc_threshold <= REG_WDATA_I;
            // timers are split into byte halves
            if (hit(PMT_REG_ON_LO)) tone_on_period[7:0] <= REG_WDATA_I[7:0];
            if (hit(PMT_REG_ON_HI)) tone_on_period[15:8] <= REG_WDATA_I[7:0];
            if (hit(PMT_REG_OFF_LO)) tone_off_period[7:0] <= REG_WDATA_I[7:0];
            if (hit(PMT_REG_OFF_HI)) tone_off_period[15:8] <= REG_WDATA_I[7:0];
        end
    end

    // control, gain, enables and impedance bits
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            tone_generator_enable <= 1'b0;
            tone_on_timer_enable <= 1'b0;
            tone_off_timer_enable <= 1'b0;
            audio_gain_control <= '0;
            interrupt_enables_first <= '0;
            impedance_synthesis_off <= PMT_RST_IMP_ON;
        end else begin
            if (hit(PMT_REG_CTRL)) begin
                tone_generator_enable <= REG_WDATA_I[PMT_CTRL_GEN_EN]; // RL10
                tone_on_timer_enable <= REG_WDATA_I[PMT_CTRL_ON_EN]; // RL10
                tone_off_timer_enable <= REG_WDATA_I[PMT_CTRL_OFF_EN]; // RL10
            end
            if (hit(PMT_REG_GAIN)) begin
                audio_gain_control <= REG_WDATA_I[4:0];
            end
            if (hit(PMT_REG_IRQ_EN)) begin
                interrupt_enables_first <= REG_WDATA_I[1:0];
            end
            if (hit(PMT_REG_IMPED)) begin
                impedance_synthesis_off <= REG_WDATA_I[PMT_IMP_ON]; // RL11
            end
        end
    end

    // cadence sequencer; the single timer serves whichever phase runs
    always_ff @(posedge CLK_I) begin
        if (!NRST_I || !tone_generator_enable) begin
            state <= PMT_IDLE;
            timer <= PMT_RST_ZERO;
        end else begin
            unique case (state)
                PMT_IDLE: begin
                    state <= PMT_ON;
                    timer <= tone_on_period; // RL8
                end
                PMT_ON: begin
                    if (tick && tone_on_timer_enable) begin
                        if (timer != PMT_RST_ZERO) begin
                            timer <= timer - 16'h0001; // RL8
                        end else if (tone_off_timer_enable) begin
                            state <= PMT_OFF; // RL17
                            timer <= tone_off_period; // RL17
                        end else begin
                            timer <= tone_on_period;
                        end
                    end
                end
                PMT_OFF: begin
                    if (tick) begin
                        if (timer != PMT_RST_ZERO) begin
                            timer <= timer - 16'h0001; // RL8
                        end else begin
                            state <= PMT_ON; // RL17
                            timer <= tone_on_period;
                        end
                    end
                end
            endcase
        end
    end

    assign on_expire = (state == PMT_ON) && tick && tone_on_timer_enable
        && (timer == PMT_RST_ZERO);
    assign off_expire = (state == PMT_OFF) && tick && (timer == PMT_RST_ZERO);
    assign tone_on = (state == PMT_ON);

    // sticky flags, cleared by reading them; a new expiry wins over the clear
    assign clear_flags = REG_RE_I && (REG_ADDR_I == PMT_REG_IRQ_FLAGS);
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            interrupt_flags_first <= '0;
        end else begin
            interrupt_flags_first[PMT_IRQ_ON] <= (on_expire
                && interrupt_enables_first[PMT_IRQ_ON]) // RL9
                || (interrupt_flags_first[PMT_IRQ_ON] && !clear_flags);
            interrupt_flags_first[PMT_IRQ_OFF] <= (off_expire
                && interrupt_enables_first[PMT_IRQ_OFF]) // RL9
                || (interrupt_flags_first[PMT_IRQ_OFF] && !clear_flags);
        end
    end

    // linear envelope: attack saturates, decay floors at zero
    assign vol_up = 17'(volume) + 17'(tone_envelope_step);
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            volume <= PMT_RST_ZERO; // RL5
        end else if (tick) begin
            if (tone_on) begin
                if (TX_LEVEL_I > tone_agc_threshold) begin
                    volume <= volume; // RL6
                end else if (vol_up > 17'(PMT_VOL_MAX)) begin
                    volume <= PMT_VOL_MAX; // RL5
                end else begin
                    volume <= vol_up[15:0]; // RL4
                end
            end else if (volume > tone_envelope_step) begin
                volume <= volume - tone_envelope_step; // RL7
            end else begin
                volume <= PMT_RST_ZERO; // RL7
            end
        end
    end
    assign tone_waveform_present = (volume != PMT_RST_ZERO); // RL10

    pmt_osc u_osc (
        .clk_i(CLK_I),
        .nrst_i(NRST_I),
        .sample_en_i(samp),
        .run_i(tone_on || tone_waveform_present),
        .coef_i(tone_frequency_coefficient),
        .ampl_i(tone_amplitude_coefficient),
        .sample_o(osc_sample)
    );

    // shape each sample by the envelope before the DAC
    assign shaped = osc_sample * $signed({1'b0, volume[14:0]});
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            TONE_DAC_O <= '0;
        end else begin
            TONE_DAC_O <= shaped[PMT_VOL_SHIFT +: 16]; // RL3
        end
    end

    // gain controls; mute dominates attenuation in the analog stage
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            TX_ATTEN_O <= 1'b0;
            TX_MUTE_O <= 1'b0;
            RX_ATTEN_O <= 2'h0;
            RX_MUTE_O <= 1'b0;
            IMPEDANCE_ON_O <= PMT_RST_IMP_ON;
        end else begin
            TX_MUTE_O <= audio_gain_control[PMT_GAIN_TX_MUTE]; // RL13
            TX_ATTEN_O <= audio_gain_control[PMT_GAIN_TX_ATT]
                && !audio_gain_control[PMT_GAIN_TX_MUTE]; // RL12
            RX_MUTE_O <= audio_gain_control[PMT_GAIN_RX_MUTE]; // RL15
            // code 11 is passed unchanged; the host must not use it
            RX_ATTEN_O <= audio_gain_control[PMT_GAIN_RX_ATT_LO +: 2]; // RL14
            IMPEDANCE_ON_O <= impedance_synthesis_off; // RL11
        end
    end

    // registered read data, zero for unmapped indices
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            REG_RDATA_O <= PMT_RST_ZERO;
        end else if (REG_RE_I) begin
            unique case (REG_ADDR_I)
                PMT_REG_FREQ: REG_RDATA_O <= tone_frequency_coefficient;
                PMT_REG_AMPL: REG_RDATA_O <= tone_amplitude_coefficient;
                PMT_REG_STEP: REG_RDATA_O <= tone_envelope_step;
                PMT_REG_ON_LO: REG_RDATA_O <= {8'h00, tone_on_period[7:0]};
                PMT_REG_ON_HI: REG_RDATA_O <= {8'h00, tone_on_period[15:8]};
                PMT_REG_OFF_LO: REG_RDATA_O <= {8'h00, tone_off_period[7:0]};
                PMT_REG_OFF_HI: REG_RDATA_O <= {8'h00, tone_off_period[15:8]};
                PMT_REG_AGC_TH: REG_RDATA_O <= tone_agc_threshold;
                PMT_REG_CTRL: REG_RDATA_O <= {12'h000, tone_waveform_present,
                    tone_off_timer_enable, tone_on_timer_enable, tone_generator_enable};
                PMT_REG_GAIN: REG_RDATA_O <= {11'h000, audio_gain_control};
                PMT_REG_IRQ_FLAGS: REG_RDATA_O <= {14'h0000, interrupt_flags_first};
                PMT_REG_IRQ_EN: REG_RDATA_O <= {14'h0000, interrupt_enables_first};
                PMT_REG_IMPED: REG_RDATA_O <= {15'h0000, impedance_synthesis_off};
                default: REG_RDATA_O <= PMT_RST_ZERO;
            endcase
        end
    end
endmodule

// [logic/pmt_osc.sv]
// pulse metering package and tone resonator
package pmt_pkg;
    // register indices on the decoded register port
    localparam logic [6:0] PMT_REG_FREQ = 7'h00;
    localparam logic [6:0] PMT_REG_AMPL = 7'h01;
    localparam logic [6:0] PMT_REG_STEP = 7'h02;
    localparam logic [6:0] PMT_REG_ON_LO = 7'h03;
    localparam logic [6:0] PMT_REG_ON_HI = 7'h04;
    localparam logic [6:0] PMT_REG_OFF_LO = 7'h05;
    localparam logic [6:0] PMT_REG_OFF_HI = 7'h06;
    localparam logic [6:0] PMT_REG_AGC_TH = 7'h07;
    localparam logic [6:0] PMT_REG_CTRL = 7'h08;
    localparam logic [6:0] PMT_REG_GAIN = 7'h09;
    localparam logic [6:0] PMT_REG_IRQ_FLAGS = 7'h0A;
    localparam logic [6:0] PMT_REG_IRQ_EN = 7'h0B;
    localparam logic [6:0] PMT_REG_IMPED = 7'h0C;
    // tone_control fields
    localparam int PMT_CTRL_GEN_EN = 0;
    localparam int PMT_CTRL_ON_EN = 1;
    localparam int PMT_CTRL_OFF_EN = 2;
    localparam int PMT_CTRL_PRESENT = 3;
    // audio_gain_control fields
    localparam int PMT_GAIN_TX_ATT = 0;
    localparam int PMT_GAIN_TX_MUTE = 1;
    localparam int PMT_GAIN_RX_ATT_LO = 2;
    localparam int PMT_GAIN_RX_MUTE = 4;
    // interrupt flag and enable fields
    localparam int PMT_IRQ_ON = 0;
    localparam int PMT_IRQ_OFF = 1;
    // impedance register field
    localparam int PMT_IMP_ON = 0;
    // reset values
    localparam logic [15:0] PMT_RST_ZERO = 16'h0000;
    localparam logic PMT_RST_IMP_ON = 1'b1;
    // envelope limits and oscillator scaling
    localparam logic [15:0] PMT_VOL_MAX = 16'h7FFF;
    localparam int PMT_VOL_SHIFT = 15;
    localparam int PMT_COEF_SHIFT = 14;
    localparam logic [15:0] PMT_FREQ_MASK = 16'hFFF8;
    // timing
    localparam int PMT_CLK_HZ = 125000000;
    localparam int PMT_TICK_HZ = 8000;
    localparam int PMT_SAMPLE_HZ = 64000;
    localparam int PMT_TICK_CYC = PMT_CLK_HZ / PMT_TICK_HZ;
    localparam int PMT_SAMPLE_CYC = PMT_CLK_HZ / PMT_SAMPLE_HZ;
    // cadence states
    typedef enum logic [1:0] {PMT_IDLE, PMT_ON, PMT_OFF} pmt_state_t;
endpackage

`timescale 1ns/1ns
// two-pole resonator: y[n] = 2c*y[n-1] - y[n-2], c in Q14
module pmt_osc import pmt_pkg::*; (
    input wire logic clk_i,                 // system clock
    input wire logic nrst_i,                // sync reset, active low
    input wire logic sample_en_i,           // 64 kHz step enable
    input wire logic run_i,                 // oscillate when high
    input wire logic [15:0] coef_i,         // frequency coefficient
    input wire logic [15:0] ampl_i,         // amplitude coefficient
    output logic signed [15:0] sample_o     // sinusoid sample
);
    logic signed [15:0] y1;
    logic signed [15:0] y2;
    logic signed [15:0] c;
    logic signed [33:0] prod;
    logic signed [33:0] next_y;

    // bits 2:0 of the coefficient carry no weight
    assign c = $signed(coef_i & PMT_FREQ_MASK); // RL1
    assign prod = 34'(c * y1) <<< 1;
    assign next_y = (prod >>> PMT_COEF_SHIFT) - 34'(y2);

    // seed with the amplitude while stopped, so a burst starts clean only if the previous one decayed to zero first
    always_ff @(posedge clk_i) begin
        if (!nrst_i || !run_i) begin
            y1 <= $signed(ampl_i); // RL2
            y2 <= $signed(PMT_RST_ZERO);
        end else if (sample_en_i) begin
            y1 <= next_y[15:0]; // RL1
            y2 <= y1;
        end
    end

    assign sample_o = y1;
endmodule

// [test/pmt_tone_gain_assertions.sv]
// assertion checker for the pulse metering tone and gain block
`timescale 1ns/1ns
module pmt_tone_gain_checker import pmt_pkg::*; (
    input wire logic CLK_I, // clock
    input wire logic NRST_I, // reset
    input wire logic [6:0] REG_ADDR_I, // index
    input wire logic [15:0] REG_WDATA_I, // wdata
    input wire logic REG_WE_I, // write
    input wire logic REG_RE_I, // read
    input wire logic [15:0] REG_RDATA_O, // rdata
    input wire logic [15:0] TX_LEVEL_I, // tx level
    input wire logic signed [15:0] TONE_DAC_O, // tone
    input wire logic TX_ATTEN_O, // tx att
    input wire logic TX_MUTE_O, // tx mute
    input wire logic [1:0] RX_ATTEN_O, // rx att
    input wire logic RX_MUTE_O, // rx mute
    input wire logic IMPEDANCE_ON_O // imp on
);
    logic [4:0] gain;
    logic imp;
    // last written gain and impedance words, outputs must follow them
    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            gain <= 5'h00;
            imp <= 1'b1;
        end else if (REG_WE_I && REG_ADDR_I == PMT_REG_GAIN) begin
            gain <= REG_WDATA_I[4:0];
        end else if (REG_WE_I && REG_ADDR_I == PMT_REG_IMPED) begin
            imp <= REG_WDATA_I[0];
        end
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    mute_wins_a: assert property (TX_MUTE_O |-> !TX_ATTEN_O)
        else $error("tx attenuation shown while muted");
    tx_gain_a: assert property (REG_WE_I && REG_ADDR_I == PMT_REG_GAIN |=> ##[0:1]
        (TX_MUTE_O == gain[1] && TX_ATTEN_O == (gain[0] & ~gain[1])))
        else $error("tx gain outputs differ from written word");
    rx_att_a: assert property (REG_WE_I && REG_ADDR_I == PMT_REG_GAIN |=> ##[0:1]
        RX_ATTEN_O == gain[3:2]) else $error("rx attenuation differs from written code");
    rx_mute_a: assert property (REG_WE_I && REG_ADDR_I == PMT_REG_GAIN |=> ##[0:1]
        RX_MUTE_O == gain[4]) else $error("rx mute differs from written bit");
    imp_follow_a: assert property (REG_WE_I && REG_ADDR_I == PMT_REG_IMPED |=> ##[0:1]
        IMPEDANCE_ON_O == imp) else $error("impedance output differs from written bit");
    ctrl_read_a: assert property (REG_RE_I && REG_ADDR_I == PMT_REG_CTRL |=>
        REG_RDATA_O[15:4] == 12'h000) else $error("control read shows unused bits");
    flags_read_a: assert property (REG_RE_I && REG_ADDR_I == PMT_REG_IRQ_FLAGS |=>
        REG_RDATA_O[15:2] == 14'h0000) else $error("flag read shows unused bits");
    timer_byte_a: assert property (REG_RE_I && REG_ADDR_I inside {[3:6]} |=>
        REG_RDATA_O[15:8] == 8'h00) else $error("timer byte read shows upper bits");
    unmapped_zero_a: assert property (REG_RE_I && REG_ADDR_I > PMT_REG_IMPED |=>
        REG_RDATA_O == 16'h0000) else $error("unmapped read not zero");
    rdata_hold_a: assert property (!REG_RE_I |=> $stable(REG_RDATA_O))
        else $error("read data moved without a read");
    mute_seen_c: cover property (REG_WE_I && REG_ADDR_I == PMT_REG_GAIN && REG_WDATA_I[1]);
    flag_seen_c: cover property (REG_RE_I && REG_ADDR_I == PMT_REG_IRQ_FLAGS ##1 REG_RDATA_O != 0);
    tone_seen_c: cover property (TONE_DAC_O != 16'sh0000);
endmodule
bind pmt_tone_gain pmt_tone_gain_checker chk (.CLK_I(CLK_I), .NRST_I(NRST_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WE_I(REG_WE_I),
    .REG_RE_I(REG_RE_I), .REG_RDATA_O(REG_RDATA_O), .TX_LEVEL_I(TX_LEVEL_I),
    .TONE_DAC_O(TONE_DAC_O), .TX_ATTEN_O(TX_ATTEN_O), .TX_MUTE_O(TX_MUTE_O),
    .RX_ATTEN_O(RX_ATTEN_O), .RX_MUTE_O(RX_MUTE_O), .IMPEDANCE_ON_O(IMPEDANCE_ON_O));

// [test/pmt_host_model.sv]
// host controller model issuing register accesses
`timescale 1ns/1ns
module pmt_host_model (
    input wire logic clk_i, // clock
    output logic [6:0] addr_o, // index
    output logic [15:0] wdata_o, // write data
    output logic we_o, // write strobe
    output logic re_o // read strobe
);
    logic [15:0] exp_q[$];
    initial begin
        addr_o = 7'h00;
        wdata_o = 16'h0000;
        we_o = 1'b0;
        re_o = 1'b0;
    end
    // one strobe per call; idle lines show the inverse so stale values never match
    task automatic access(input logic is_wr, input logic [6:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        we_o <= is_wr;
        re_o <= ~is_wr;
        @(posedge clk_i);
        we_o <= 1'b0;
        re_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        access(1'b1, a, d);
    endtask
    // the expectation is noted before the strobe leaves
    task automatic rd(input logic [6:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        access(1'b0, a, 16'h0000);
    endtask
endmodule

// [test/pulse_metering_tone_and_audio_gain_test.sv]
// self-checking bench for the pulse metering tone and audio gain block
`timescale 1ns/1ns
module pulse_metering_tone_and_audio_gain_test import pmt_pkg::*;;
    localparam int TK = 16;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [15:0] tx_level = 16'h0000;
    logic [6:0] addr;
    logic [15:0] wdata;
    logic we;
    logic re;
    logic [15:0] rdata;
    logic signed [15:0] dac;
    logic tx_att;
    logic tx_mute;
    logic [1:0] rx_att;
    logic rx_mute;
    logic imp_on;
    logic rd_seen = 1'b0;
    int n_errors = 0;
    int compares = 0;
    int nz;
    logic [15:0] v;
    always #4 clk = ~clk;
    pmt_host_model host (.clk_i(clk), .addr_o(addr), .wdata_o(wdata), .we_o(we), .re_o(re));
    // short tick and sample periods keep the cadence run brief
    pmt_tone_gain #(.TICK_CYC(TK), .SAMPLE_CYC(4)) dut (.CLK_I(clk), .NRST_I(nrst),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WE_I(we), .REG_RE_I(re),
        .REG_RDATA_O(rdata), .TX_LEVEL_I(tx_level), .TONE_DAC_O(dac), .TX_ATTEN_O(tx_att),
        .TX_MUTE_O(tx_mute), .RX_ATTEN_O(rx_att), .RX_MUTE_O(rx_mute), .IMPEDANCE_ON_O(imp_on));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // counts nonzero tone samples over n cycles
    task automatic span(input int n);
        nz = 0;
        repeat (n) begin
            @(posedge clk);
            if (dac !== 16'sh0000) nz++;
        end
    endtask
    task automatic gain_case(input logic [4:0] g);
        host.wr(PMT_REG_GAIN, {11'h000, g});
        repeat (2) @(posedge clk);
        check("tx attenuation", {15'h0000, tx_att}, {15'h0000, g[0] & ~g[1]});
        check("tx mute", {15'h0000, tx_mute}, {15'h0000, g[1]});
        check("rx attenuation", {14'h0000, rx_att}, {14'h0000, g[3:2]});
        check("rx mute", {15'h0000, rx_mute}, {15'h0000, g[4]});
        host.rd(PMT_REG_GAIN, {11'h000, g});
    endtask
    // read answers arrive one cycle after the strobe edge, oldest note first
    always @(posedge clk) begin
        if (rd_seen) check("read data", rdata, host.exp_q.pop_front());
        rd_seen <= re;
    end
    initial begin
        repeat (4000) @(posedge clk);
        n_errors++;
        wrap_up();
    end
    initial begin
        void'($urandom(79));
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        check("impedance on", {15'h0000, imp_on}, 16'h0001);
        for (int a = 0; a <= 12; a++) host.rd(7'(a), (a == 12) ? 16'h0001 : 16'h0000);
        for (int a = 0; a <= 7; a++) begin
            v = 16'($urandom);
            if (a == 0) v[2:0] = 3'h0;
            if (a >= 3 && a <= 6) v[15:8] = 8'h00;
            host.wr(7'(a), v);
            host.rd(7'(a), v);
        end
        host.wr(7'h0D, 16'hFFFF);
        host.rd(7'h0D, 16'h0000);
        host.rd(7'h7F, 16'h0000);
        host.wr(PMT_REG_CTRL, 16'h000E);
        host.rd(PMT_REG_CTRL, 16'h0006);
        host.wr(PMT_REG_CTRL, 16'h0000);
        for (int b = 0; b < 2; b++) begin
            host.wr(PMT_REG_IMPED, 16'(b));
            repeat (2) @(posedge clk);
            check("impedance on", {15'h0000, imp_on}, 16'(b));
        end
        // code 11 of the receive field is never sent
        for (int g = 0; g < 32; g++) if (g[3:2] != 2'b11) gain_case(5'(g));
        host.wr(PMT_REG_FREQ, 16'h1878);
        host.wr(PMT_REG_AMPL, 16'h2000);
        host.wr(PMT_REG_STEP, 16'h4000);
        host.wr(PMT_REG_AGC_TH, 16'h0100);
        tx_level <= 16'hFFFF;
        host.wr(PMT_REG_CTRL, 16'h0001);
        span(6 * TK);
        check("clipped envelope", 16'(nz), 16'h0000);
        tx_level <= 16'h0000;
        span(4 * TK);
        check("tone running", {15'h0000, nz != 0}, 16'h0001);
        host.rd(PMT_REG_CTRL, 16'h0009);
        host.wr(PMT_REG_CTRL, 16'h0000);
        // an abrupt cut would empty the output within one tick
        span(2 * TK);
        check("gradual decay", {15'h0000, nz > TK}, 16'h0001);
        repeat (2 * TK) @(posedge clk);
        span(2 * TK);
        check("decayed tone", 16'(nz), 16'h0000);
        host.rd(PMT_REG_CTRL, 16'h0000);
        host.wr(PMT_REG_ON_LO, 16'h0002);
        host.wr(PMT_REG_ON_HI, 16'h0000);
        host.wr(PMT_REG_OFF_LO, 16'h0003);
        host.wr(PMT_REG_OFF_HI, 16'h0000);
        host.wr(PMT_REG_IRQ_EN, 16'h0003);
        host.wr(PMT_REG_CTRL, 16'h0007);
        repeat (118) @(posedge clk);
        host.rd(PMT_REG_IRQ_FLAGS, 16'h0003);
        host.rd(PMT_REG_IRQ_FLAGS, 16'h0000);
        host.wr(PMT_REG_IRQ_EN, 16'h0001);
        repeat (100) @(posedge clk);
        host.rd(PMT_REG_IRQ_FLAGS, 16'h0001);
        host.wr(PMT_REG_CTRL, 16'h0000);
        // on timer alone reloads itself and never enters the off phase
        host.wr(PMT_REG_IRQ_EN, 16'h0003);
        host.wr(PMT_REG_CTRL, 16'h0003);
        repeat (118) @(posedge clk);
        host.rd(PMT_REG_IRQ_FLAGS, 16'h0001);
        host.wr(PMT_REG_CTRL, 16'h0000);
        repeat (4) @(posedge clk);
        wrap_up();
    end
endmodule
